// file: src/ppeiu_defines.svh
// register offsets, field positions and reset values of the port event interrupt unit
`ifndef PPEIU_DEFINES_SVH
`define PPEIU_DEFINES_SVH

`define PPEIU_ADDR_W            8
`define PPEIU_OFF_SUMMARY       8'h00
`define PPEIU_OFF_ENABLE        8'h01
`define PPEIU_OFF_POWER_VIEW    8'h02
`define PPEIU_OFF_POWER_COR     8'h03
`define PPEIU_OFF_DETECT_VIEW   8'h04
`define PPEIU_OFF_DETECT_COR    8'h05
`define PPEIU_OFF_FAULT_VIEW    8'h06
`define PPEIU_OFF_FAULT_COR     8'h07
`define PPEIU_OFF_STARTUP_VIEW  8'h08
`define PPEIU_OFF_STARTUP_COR   8'h09
`define PPEIU_OFF_SUPPLY_VIEW   8'h0a
`define PPEIU_OFF_SUPPLY_COR    8'h0b

`define PPEIU_EVT_RESET         8'h00
`define PPEIU_SUMMARY_RESET     8'h00
`define PPEIU_READ_ZERO         8'h00
`define PPEIU_ENABLE_AUTO_MASK  8'he4
// edges after reset release before the strap synchroniser holds the pin level
`define PPEIU_STRAP_WAIT        2'h2

`define PPEIU_BIT_SUPPLY        7
`define PPEIU_BIT_STARTUP       6
`define PPEIU_BIT_OVERCURRENT   5
`define PPEIU_BIT_CLASSIFY      4
`define PPEIU_BIT_DETECT        3
`define PPEIU_BIT_DISCONNECT    2
`define PPEIU_BIT_PORT_POWER_GOOD         1
`define PPEIU_BIT_PWRON         0

`define PPEIU_HI_LSB            4
`define PPEIU_LO_LSB            0

`endif

// file: src/ppeiu_pkg.sv
// types of the port event interrupt unit
package ppeiu_pkg;

  typedef logic [7:0] ppeiu_byte_t;

  typedef struct packed {
    ppeiu_byte_t power_evt;
    ppeiu_byte_t detect_evt;
    ppeiu_byte_t fault_evt;
    ppeiu_byte_t startup_evt;
    ppeiu_byte_t supply_evt;
    ppeiu_byte_t summary;
    ppeiu_byte_t enable_bits;
    ppeiu_byte_t rd_data;
    logic        irq_n;
    logic [3:0]  port_power_good_s1;
    logic [3:0]  port_power_good_s2;
    logic [3:0]  port_power_good_s3;
    logic [3:0]  pwron_s1;
    logic [3:0]  pwron_s2;
    logic [3:0]  pwron_s3;
    logic        auto_s1;
    logic        auto_s2;
    logic        strap_done;
    logic [1:0]  strap_cnt;
  } ppeiu_state_t;

endpackage : ppeiu_pkg

// file: src/ppeiu_top.sv
// event flag registers, summary, mask and interrupt pin of the four-port power controller
//
// Notes on behaviour
// - summary bit 7 is the OR of all supply event bits.
// - summary bit 6 is the OR of all startup event bits.
// - summary bit 5 is the OR of fault event bits 3..0.
// - summary bit 4 is the OR of detect event bits 7..4.
// - summary bit 3 is the OR of detect event bits 3..0.
// - summary bit 2 is the OR of fault event bits 7..4.
// - summary bit 1 is the OR of power event bits 7..4.
// - summary bit 0 is the OR of power event bits 3..0.
// - each enable bit gates the summary bit at its own position.
// - power-good change sets bits 7..4, power-on change sets bits 3..0.
// - those change flags follow edges of the status, not its level.
// - event registers read at even offset unchanged, at odd offset then cleared.
// - reset clears power, detect, fault, startup and supply event registers.
// - detection done sets bits 3..0, classification done bits 7..4.
// - load removal shutdown sets fault bits 7..4 of that port.
// - overcurrent shutdown after good startup sets fault bits 3..0.
// - startup failure shutdown sets startup bits 3..0 of that port.
// - class overcurrent sets startup bits 7..4 of that port.
// - class limit bit on makes ports limit current by class.
// - interrupt pin goes low while an enabled summary event stands.
// - global clear bit clears summary and all event registers at once.
// - global enable zero holds interrupt off whatever the mask.
// - summary resets to zero; enable bits 7,6,5,2 copy the auto strap.
`timescale 1ns/1ps
`include "ppeiu_defines.svh"

module ppeiu_top #(
  parameter int PORTS = 4
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // register access from the serial engine, same clock
  input  wire logic                        reg_rd_in,
  input  wire logic                        reg_wr_in,
  input  wire logic [`PPEIU_ADDR_W-1:0]    reg_addr_in,
  input  wire ppeiu_pkg::ppeiu_byte_t      reg_wdata_in,
  output ppeiu_pkg::ppeiu_byte_t           reg_rdata_out,
  // global control bits held elsewhere in the register file
  input  wire logic                        irq_global_enable_in,
  input  wire logic                        global_clear_in,
  input  wire logic                        class_current_limit_on_in,
  output logic                             class_current_limit_on_out,
  // auto-mode strap pin, asynchronous
  input  wire logic                        auto_mode_in,
  // port status levels, asynchronous
  input  wire logic [3:0]                  port_power_good_in,
  input  wire logic [3:0]                  port_power_on_in,
  // one-cycle event pulses from port logic, same clock
  input  wire logic [3:0]                  port_detect_done_in,
  input  wire logic [3:0]                  port_classify_done_in,
  input  wire logic [3:0]                  port_load_removed_in,
  input  wire logic [3:0]                  port_overcurrent_in,
  input  wire logic [3:0]                  port_startup_failed_in,
  input  wire logic [3:0]                  port_class_overcurrent_in,
  input  wire ppeiu_pkg::ppeiu_byte_t      supply_event_in,
  // open-drain interrupt pin, low active
  output logic                             irq_n_out,
  output logic                             irq_oe_out,
  output ppeiu_pkg::ppeiu_byte_t           summary_out
);
  import ppeiu_pkg::*;

  initial begin
    if (PORTS != 4) $error("ppeiu_top serves exactly four ports");
  end

  ppeiu_state_t st_r;
  ppeiu_state_t st_nxt;
  ppeiu_byte_t  enable_out_r;
  logic         climit_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]  pg_edge;
    logic [3:0]  pe_edge;
    ppeiu_byte_t sum_v;
    ppeiu_byte_t clr_pw;
    ppeiu_byte_t clr_dt;
    ppeiu_byte_t clr_ft;
    ppeiu_byte_t clr_st;
    ppeiu_byte_t clr_sp;
    logic        rd_cor;
    st_nxt = st_r;
    pg_edge = '0;
    pe_edge = '0;
    sum_v = `PPEIU_SUMMARY_RESET;
    clr_pw = '0;
    clr_dt = '0;
    clr_ft = '0;
    clr_st = '0;
    clr_sp = '0;
    rd_cor = 1'b0;

    // status pins: two stages, then a third for the edge compare
    st_nxt.port_power_good_s1 = port_power_good_in;
    st_nxt.port_power_good_s2 = st_r.port_power_good_s1;
    st_nxt.port_power_good_s3 = st_r.port_power_good_s2;
    st_nxt.pwron_s1 = port_power_on_in;
    st_nxt.pwron_s2 = st_r.pwron_s1;
    st_nxt.pwron_s3 = st_r.pwron_s2;
    st_nxt.auto_s1 = auto_mode_in;
    st_nxt.auto_s2 = st_r.auto_s1;

    // strap caught once, only after both synchroniser stages hold the pin level
    if (!st_r.strap_done) begin
      if (st_r.strap_cnt == `PPEIU_STRAP_WAIT) begin
        st_nxt.strap_done = 1'b1;
        st_nxt.enable_bits = st_r.auto_s2 ? `PPEIU_ENABLE_AUTO_MASK : `PPEIU_READ_ZERO;
      end else begin
        st_nxt.strap_cnt = 2'(st_r.strap_cnt + 2'h1);
      end
    end

    pg_edge = st_r.port_power_good_s2 ^ st_r.port_power_good_s3;
    pe_edge = st_r.pwron_s2 ^ st_r.pwron_s3;

    rd_cor = reg_rd_in;
    if (rd_cor) begin
      unique case (reg_addr_in)
        `PPEIU_OFF_POWER_COR:   clr_pw = st_r.power_evt;
        `PPEIU_OFF_DETECT_COR:  clr_dt = st_r.detect_evt;
        `PPEIU_OFF_FAULT_COR:   clr_ft = st_r.fault_evt;
        `PPEIU_OFF_STARTUP_COR: clr_st = st_r.startup_evt;
        `PPEIU_OFF_SUPPLY_COR:  clr_sp = st_r.supply_evt;
        default: ;
      endcase
    end
    if (global_clear_in) begin
      clr_pw = '1;
      clr_dt = '1;
      clr_ft = '1;
      clr_st = '1;
      clr_sp = '1;
    end

    // new events are ORed in after the clear, so the set wins
    st_nxt.power_evt = (st_r.power_evt & ~clr_pw) | {pg_edge, pe_edge};
    st_nxt.detect_evt = (st_r.detect_evt & ~clr_dt)
                      | {port_classify_done_in, port_detect_done_in};
    st_nxt.fault_evt = (st_r.fault_evt & ~clr_ft)
                     | {port_load_removed_in, port_overcurrent_in};
    st_nxt.startup_evt = (st_r.startup_evt & ~clr_st)
                       | {port_class_overcurrent_in, port_startup_failed_in};
    st_nxt.supply_evt = (st_r.supply_evt & ~clr_sp) | supply_event_in;

    // summary follows the flags of the next cycle
    sum_v[`PPEIU_BIT_SUPPLY] = |st_nxt.supply_evt;
    sum_v[`PPEIU_BIT_STARTUP] = |st_nxt.startup_evt;
    sum_v[`PPEIU_BIT_OVERCURRENT] = |st_nxt.fault_evt[`PPEIU_LO_LSB +: 4];
    sum_v[`PPEIU_BIT_CLASSIFY] = |st_nxt.detect_evt[`PPEIU_HI_LSB +: 4];
    sum_v[`PPEIU_BIT_DETECT] = |st_nxt.detect_evt[`PPEIU_LO_LSB +: 4];
    sum_v[`PPEIU_BIT_DISCONNECT] = |st_nxt.fault_evt[`PPEIU_HI_LSB +: 4];
    sum_v[`PPEIU_BIT_PORT_POWER_GOOD] = |st_nxt.power_evt[`PPEIU_HI_LSB +: 4];
    sum_v[`PPEIU_BIT_PWRON] = |st_nxt.power_evt[`PPEIU_LO_LSB +: 4];
    st_nxt.summary = sum_v;

    if (reg_wr_in && reg_addr_in == `PPEIU_OFF_ENABLE && st_r.strap_done) begin
      st_nxt.enable_bits = reg_wdata_in;
    end

    // pin low exactly while global enable is set and an enabled summary bit stands
    st_nxt.irq_n = ~(irq_global_enable_in
                     && |(sum_v & st_nxt.enable_bits));

    // read data registered one cycle after the strobe
    st_nxt.rd_data = `PPEIU_READ_ZERO;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `PPEIU_OFF_SUMMARY:      st_nxt.rd_data = st_r.summary;
        `PPEIU_OFF_ENABLE:       st_nxt.rd_data = st_r.enable_bits;
        `PPEIU_OFF_POWER_VIEW,
        `PPEIU_OFF_POWER_COR:    st_nxt.rd_data = st_r.power_evt;
        `PPEIU_OFF_DETECT_VIEW,
        `PPEIU_OFF_DETECT_COR:   st_nxt.rd_data = st_r.detect_evt;
        `PPEIU_OFF_FAULT_VIEW,
        `PPEIU_OFF_FAULT_COR:    st_nxt.rd_data = st_r.fault_evt;
        `PPEIU_OFF_STARTUP_VIEW,
        `PPEIU_OFF_STARTUP_COR:  st_nxt.rd_data = st_r.startup_evt;
        `PPEIU_OFF_SUPPLY_VIEW,
        `PPEIU_OFF_SUPPLY_COR:   st_nxt.rd_data = st_r.supply_evt;
        default:                 st_nxt.rd_data = `PPEIU_READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.irq_n <= 1'b1;
      climit_r <= 1'b0;
      enable_out_r <= `PPEIU_READ_ZERO;
    end else begin
      st_r <= st_nxt;
      climit_r <= class_current_limit_on_in;
      enable_out_r <= st_nxt.enable_bits;
    end
  end

  assign reg_rdata_out = st_r.rd_data;
  assign irq_n_out = st_r.irq_n;
  // open drain: drive only while low
  assign irq_oe_out = ~st_r.irq_n;
  assign summary_out = st_r.summary;
  assign class_current_limit_on_out = climit_r;

endmodule : ppeiu_top

// file: sim/ppeiu_monitor.sv
// concurrent checks on the port event interrupt unit ports
`timescale 1ns/1ps
module ppeiu_monitor (
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   reg_rd_in,
  input wire logic [7:0]             reg_addr_in,
  input wire logic                   irq_global_enable_in,
  input wire logic                   global_clear_in,
  input wire logic [3:0]             port_power_good_in,
  input wire logic [3:0]             port_load_removed_in,
  input wire logic [3:0]             port_overcurrent_in,
  input wire logic [3:0]             port_class_overcurrent_in,
  input wire ppeiu_pkg::ppeiu_byte_t reg_rdata_out,
  input wire logic                   irq_n_out,
  input wire logic                   irq_oe_out,
  input wire ppeiu_pkg::ppeiu_byte_t summary_out
);
  import ppeiu_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_cor_fault;
    reg_rd_in && reg_addr_in == 8'h07 && port_overcurrent_in == 4'h0 &&
      port_load_removed_in == 4'h0 && !global_clear_in;
  endsequence
  sequence s_fault_gone;
    !summary_out[5] && !summary_out[2];
  endsequence
  chk_oe_level: assert property (irq_oe_out == !irq_n_out)
    else $error("pin enable and interrupt level disagree");
  chk_quiet_irq: assert property (summary_out == 8'h00 |-> irq_n_out)
    else $error("interrupt low with empty summary");
  chk_global_off: assert property (!$past(irq_global_enable_in) |-> irq_n_out)
    else $error("interrupt low while globally disabled");
  chk_ovc_sets: assert property (port_overcurrent_in != 4'h0 && !global_clear_in |=>
    summary_out[5])
    else $error("overcurrent did not reach summary");
  chk_class_sets: assert property (port_class_overcurrent_in != 4'h0 && !global_clear_in
    |=> summary_out[6])
    else $error("class overcurrent did not reach summary");
  chk_cor_clears: assert property (s_cor_fault |=> s_fault_gone)
    else $error("clearing read left fault summary set");
  chk_view_keeps: assert property (reg_rd_in && reg_addr_in == 8'h06 && summary_out[5] &&
    !global_clear_in |=> summary_out[5])
    else $error("plain read cleared fault flag");
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read");
  chk_pg_change: assert property ($changed(port_power_good_in) |-> ##[2:6] summary_out[1])
    else $error("power good change not flagged");
endmodule : ppeiu_monitor

bind ppeiu_top ppeiu_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .irq_global_enable_in(irq_global_enable_in),
  .global_clear_in(global_clear_in), .port_power_good_in(port_power_good_in),
  .port_load_removed_in(port_load_removed_in), .port_overcurrent_in(port_overcurrent_in),
  .port_class_overcurrent_in(port_class_overcurrent_in), .reg_rdata_out(reg_rdata_out),
  .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out), .summary_out(summary_out));

// file: sim/ppeiu_host_model.sv
// host side of the open-drain interrupt line
`timescale 1ns/1ps
module ppeiu_host_model (
  input  wire logic irq_oe_in,
  output logic      irq_line_out
);
  // pull-up holds the line high whenever nobody sinks it
  assign irq_line_out = irq_oe_in ? 1'b0 : 1'b1;
endmodule : ppeiu_host_model

// file: sim/tb_top.sv
// self-checking bench for the port event interrupt unit
`timescale 1ns/1ps
module tb_top;
  import ppeiu_pkg::*;
  logic        clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, ge = 0, gc = 0, cl = 0;
  logic [7:0]  addr = 0, wd = 0, sup = 0;
  logic [3:0]  pg = 0, pe = 0, det = 0, cls = 0, ld = 0, oc = 0, sf = 0, co = 0;
  ppeiu_byte_t rdata, summ;
  logic        irq_n, oe, clo, line;
  logic        am = 1'b1;
  int          mismatches = 0, cmp_count = 0;
  logic [7:0]  va [8] = '{8'h02, 8'h02, 8'h06, 8'h04, 8'h04, 8'h06, 8'h08, 8'h0a};
  ppeiu_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata), .irq_global_enable_in(ge),
    .global_clear_in(gc), .class_current_limit_on_in(cl), .class_current_limit_on_out(clo),
    .auto_mode_in(am), .port_power_good_in(pg), .port_power_on_in(pe),
    .port_detect_done_in(det), .port_classify_done_in(cls), .port_load_removed_in(ld),
    .port_overcurrent_in(oc), .port_startup_failed_in(sf), .port_class_overcurrent_in(co),
    .supply_event_in(sup), .irq_n_out(irq_n), .irq_oe_out(oe), .summary_out(summ));
  ppeiu_host_model host (.irq_oe_in(oe), .irq_line_out(line));
  initial forever #10 clk_in = ~clk_in;
  // ----
  // bus and compare helpers
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    rd   <= !w;
    wr   <= w;
    addr <= a;
    wd   <= d;
    cyc(1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    #1 chk(rdata, e);
  endtask : rdc
  // one source per summary bit; pins toggle, so a second pass gives falling edges
  task automatic fire(input int i, input int p);
    cyc(1);
    case (i)
      0: pe[p] <= !pe[p];
      1: pg[p] <= !pg[p];
      2: ld[p] <= 1'b1;
      3: det[p] <= 1'b1;
      4: cls[p] <= 1'b1;
      5: oc[p] <= 1'b1;
      6: co[p] <= 1'b1;
      default: sup[p] <= 1'b1;
    endcase
    cyc(1);
    {sup, det, cls, ld, oc, co} <= '0;
  endtask : fire
  // ----
  // scenarios
  // ----
  task automatic t_map();
    logic [7:0] v;
    for (int n = 0; n < 16; n++) begin
      v = 8'h01 << (n % 4 + (8'h56 >> (n % 8) & 1) * 4);
      fire(n % 8, n % 4);
      cyc(6);
      #1 chk(summ, 8'h01 << (n % 8));
      rdc(va[n % 8], v);
      rdc(va[n % 8] | 8'h01, v);
      rdc(va[n % 8], 8'h00);
      chk(summ, 8'h00);
    end
  endtask : t_map
  task automatic t_mask();
    cyc(1);
    ge <= 1'b1;
    acc(1'b1, 8'h01, 8'h00);
    fire(5, 0);
    cyc(3);
    #1 chk(line, 1'b1);
    acc(1'b1, 8'h01, 8'h20);
    cyc(3);
    #1 chk(line, 1'b0);
    cyc(1);
    ge <= 1'b0;
    cyc(3);
    #1 chk(line, 1'b1);
    cyc(1);
    ge <= 1'b1;
    gc <= 1'b1;
    cl <= 1'b1;
    cyc(1);
    gc <= 1'b0;
    cyc(2);
    #1 chk(summ, 8'h00);
    chk(line, 1'b1);
    chk(clo, 1'b1);
  endtask : t_mask
  task automatic t_race();
    cyc(1);
    sf <= 4'h1;
    cyc(1);
    sf   <= 4'h2;
    rd   <= 1'b1;
    addr <= 8'h09;
    cyc(1);
    sf <= 4'h0;
    rd <= 1'b0;
    #1 chk(rdata, 8'h01);
    rdc(8'h08, 8'h02);
    chk(summ, 8'h40);
  endtask : t_race
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    cyc(5);
    rst_n_in <= 1'b1;
    cyc(4);
    for (int a = 0; a < 13; a++) rdc(a[7:0], a == 1 ? 8'he4 : 8'h00);
    t_map();
    t_mask();
    t_race();
    close_out();
  end
  initial begin
    cyc(5000);
    mismatches++;
    close_out();
  end
endmodule : tb_top
